/* dma_status_pkg.sv */
// package for the two-channel dma status-reporting block
// assumes a single 50 MHz clock domain and a host-side read port supplied by the enclosing controller
package dma_status_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] dma_channel1_status_off = 12'hD3C;
  localparam logic [11:0] dma_channel2_status_off = 12'hE3C;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int int_bit            = 31;
  localparam int done_bit           = 25;
  localparam int error_bit          = 15;
  localparam int cancel_bit         = 14;
  localparam int halt_bit           = 12;
  localparam int xfer_fault_bit     = 9;
  localparam int src_code_lsb       = 2;
  localparam int dst_code_lsb       = 0;

  // reserved bits read as zero
  localparam logic [31:0] status_reset = 32'h0000_0000;

  // ----------------------------------------------------------------
  // fault codes
  // ----------------------------------------------------------------
  localparam logic [1:0] fault_none   = 2'h0;
  localparam logic [1:0] fault_bus    = 2'h1;
  localparam logic [1:0] fault_retry  = 2'h2;
  localparam logic [1:0] fault_parity = 2'h3;

  // ----------------------------------------------------------------
  // retry limit
  // ----------------------------------------------------------------
  localparam int          retry_limit   = 64;
  localparam logic [6:0]  retry_max_cnt = 7'h40;

  // ----------------------------------------------------------------
  // per-channel event carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       op_start;     // operation begins, pulse
    logic       op_end;       // operation terminated, pulse
    logic       abort_wr;     // 1 written to abort command bit, pulse
    logic       stop_wr;      // 1 written to stop command bit, pulse
    logic       xfer_done;    // data transfer finished successfully, pulse
    logic       ack_valid;    // a transfer acknowledge outcome arrives, pulse
    logic       ack_dest;     // 1: destination side, 0: source side
    logic       ack_bus_err;  // bus error acknowledge
    logic       ack_retry;    // retry acknowledge
    logic       ack_parity;   // expansion bus parity error, source data cycle
    logic       irq_active;   // channel drives its dma interrupt
  } chan_event_t;

  typedef struct packed {
    logic       retry_again;  // reissue the transfer
    logic       terminate;    // end operation on fault
  } chan_cmd_t;

endpackage

/* dma_chan_status.sv */
// one channel's status word with fault tracking and retry limit
// assumes event inputs are one-cycle pulses synchronous to mclk
`timescale 1ns/1ps
module dma_chan_status (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire dma_status_pkg::chan_event_t ev,
  output logic [31:0]                      status_word,
  output dma_status_pkg::chan_cmd_t        cmd
);

  logic       done_reg;
  logic       error_reg;
  logic       cancel_reg;
  logic       halt_reg;
  logic       xfer_fault_reg;
  logic [1:0] src_code_reg;
  logic [1:0] dst_code_reg;
  logic [6:0] retry_cnt_reg;
  logic       int_reg;
  logic       fault_now;
  logic       retry_over;
  logic [1:0] fault_code;

  // ----------------------------------------------------------------
  // fault decode
  // ----------------------------------------------------------------
  assign retry_over = ev.ack_valid && ev.ack_retry && (retry_cnt_reg == dma_status_pkg::retry_max_cnt);
  always_comb begin
    fault_code = dma_status_pkg::fault_none;
    if (ev.ack_valid && ev.ack_bus_err) begin
      fault_code = dma_status_pkg::fault_bus;
    end else if (retry_over) begin
      fault_code = dma_status_pkg::fault_retry;
    end else if (ev.ack_valid && ev.ack_parity && !ev.ack_dest) begin
      fault_code = dma_status_pkg::fault_parity;
    end
  end
  assign fault_now = (fault_code != dma_status_pkg::fault_none);

  // ----------------------------------------------------------------
  // retry counter, per transfer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      retry_cnt_reg <= 7'h00;
    end else if (clk_en) begin
      if (ev.op_start || ev.xfer_done || fault_now) begin
        retry_cnt_reg <= 7'h00;
      end else if (ev.ack_valid && ev.ack_retry) begin
        retry_cnt_reg <= retry_cnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (clk_en) begin
      // a fault on the same acknowledge wins, so the two replies never overlap
      cmd.retry_again <= ev.ack_valid && ev.ack_retry && !fault_now;
      cmd.terminate   <= fault_now;
    end
  end

  // ----------------------------------------------------------------
  // completion and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      int_reg  <= 1'b0;
    end else if (clk_en) begin
      int_reg <= ev.irq_active;
      // end wins over start so a same-cycle finish is not lost
      if (ev.op_end) begin
        done_reg <= 1'b1;
      end else if (ev.op_start) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // error flags; set wins over the start clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      error_reg      <= 1'b0;
      cancel_reg     <= 1'b0;
      halt_reg       <= 1'b0;
      xfer_fault_reg <= 1'b0;
      src_code_reg   <= dma_status_pkg::fault_none;
      dst_code_reg   <= dma_status_pkg::fault_none;
    end else if (clk_en) begin
      if (ev.op_start) begin
        error_reg      <= 1'b0;
        cancel_reg     <= 1'b0;
        halt_reg       <= 1'b0;
        xfer_fault_reg <= 1'b0;
        src_code_reg   <= dma_status_pkg::fault_none;
        dst_code_reg   <= dma_status_pkg::fault_none;
      end
      if (fault_now) begin
        error_reg      <= 1'b1;
        xfer_fault_reg <= 1'b1;
        if (ev.ack_dest) begin
          dst_code_reg <= fault_code;
        end else begin
          src_code_reg <= fault_code;
        end
      end
      if (ev.abort_wr) begin
        cancel_reg <= 1'b1;
      end
      if (ev.stop_wr) begin
        halt_reg <= 1'b1;
      end
    end
  end

  // reserved bits read as zero
  always_comb begin
    status_word                                 = dma_status_pkg::status_reset;
    status_word[dma_status_pkg::int_bit]        = int_reg;
    status_word[dma_status_pkg::done_bit]       = done_reg;
    status_word[dma_status_pkg::error_bit]      = error_reg;
    status_word[dma_status_pkg::cancel_bit]     = cancel_reg;
    status_word[dma_status_pkg::halt_bit]       = halt_reg;
    status_word[dma_status_pkg::xfer_fault_bit] = xfer_fault_reg;
    status_word[dma_status_pkg::src_code_lsb +: 2] = src_code_reg;
    status_word[dma_status_pkg::dst_code_lsb +: 2] = dst_code_reg;
  end

endmodule

/* dma_status_top.sv */
// two-channel dma status reporting: status words and registered host read port
// assumes the enclosing controller drives events as single-cycle pulses on mclk
// ----------------------------------------------------------------
// Summary of operation
// - bit 31 mirrors whether the channel currently drives its dma interrupt
// - completion flag clears on operation start, sets on any termination
// - completion flag is pollable and feeds the interrupt source output
// - error flag sets when the operation ends on an error condition
// - cancel flag sets when software writes 1 to the abort command bit
// - halt-requested flag sets on stop command write; completion shows real halt
// - transfer-fault flag sets when a source or destination access faults
// - source code: 00 none, 01 bus, 10 retry limit, 11 parity
// - destination code: 00 none, 01 bus error, 10 retry limit
// - retry up to 64 times; the 65th retry terminates with retry fault
// - reserved status bits carry no meaning; here they read zero
// ----------------------------------------------------------------
`timescale 1ns/1ps
module dma_status_top (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire dma_status_pkg::chan_event_t ch1_ev,
  input  wire dma_status_pkg::chan_event_t ch2_ev,
  input  wire logic                        rd_en,
  input  wire logic [11:0]                 rd_addr,
  output logic [31:0]                      rd_data,
  output logic                             rd_valid,
  output logic                             ch1_done_irq_src,
  output logic                             ch2_done_irq_src,
  output dma_status_pkg::chan_cmd_t        ch1_cmd,
  output dma_status_pkg::chan_cmd_t        ch2_cmd
);

  logic [31:0]                 ch1_word;
  logic [31:0]                 ch2_word;
  dma_status_pkg::chan_event_t ev_arr   [2];
  logic [31:0]                 word_arr [2];
  dma_status_pkg::chan_cmd_t   cmd_arr  [2];

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  assign ev_arr[0] = ch1_ev;
  assign ev_arr[1] = ch2_ev;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      dma_chan_status u_dma_chan_status (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .ev          (ev_arr[g]),
        .status_word (word_arr[g]),
        .cmd         (cmd_arr[g])
      );
    end
  endgenerate

  assign ch1_word = word_arr[0];
  assign ch2_word = word_arr[1];
  assign ch1_cmd  = cmd_arr[0];
  assign ch2_cmd  = cmd_arr[1];

  // ----------------------------------------------------------------
  // done as interrupt source; routing lives elsewhere
  // ----------------------------------------------------------------
  assign ch1_done_irq_src = ch1_word[dma_status_pkg::done_bit];
  assign ch2_done_irq_src = ch2_word[dma_status_pkg::done_bit];

  // ----------------------------------------------------------------
  // read port; unmapped offsets return zero, read has no side effect
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_en;
      if (rd_en && rd_addr == dma_status_pkg::dma_channel1_status_off) begin
        rd_data <= ch1_word;
      end else if (rd_en && rd_addr == dma_status_pkg::dma_channel2_status_off) begin
        rd_data <= ch2_word;
      end else if (rd_en) begin
        rd_data <= 32'h0000_0000;
      end
    end
  end

endmodule

/* dma_status_props.sv */
// concurrent checks on the ports of the two-channel status block
// assumes one mclk domain with an active-low asynchronous reset
`timescale 1ns/1ps
module dma_status_props (
  input wire logic                        mclk,
  input wire logic                        rst_n,
  input wire logic                        clk_en,
  input wire dma_status_pkg::chan_event_t ch1_ev,
  input wire dma_status_pkg::chan_event_t ch2_ev,
  input wire logic                        rd_en,
  input wire logic [11:0]                 rd_addr,
  input wire logic [31:0]                 rd_data,
  input wire logic                        rd_valid,
  input wire logic                        ch1_done_irq_src,
  input wire logic                        ch2_done_irq_src,
  input wire dma_status_pkg::chan_cmd_t   ch1_cmd,
  input wire dma_status_pkg::chan_cmd_t   ch2_cmd
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_done_set: assert property (clk_en && ch1_ev.op_end |=> ch1_done_irq_src)
    else $error("done flag not set after operation end");
  a_done_clear: assert property (clk_en && ch1_ev.op_start && !ch1_ev.op_end |=> !ch1_done_irq_src)
    else $error("done flag not cleared at operation start");
  a_done_cause: assert property ($rose(ch2_done_irq_src) |-> $past(ch2_ev.op_end))
    else $error("done interrupt source rose without an operation end");
  a_read_answer: assert property (clk_en && rd_en |=> rd_valid)
    else $error("read not answered one cycle later");
  a_read_single: assert property (clk_en && !rd_en |=> !rd_valid)
    else $error("read valid without a read request");
  a_unmapped_zero: assert property (clk_en && rd_en && rd_addr != 12'hD3C && rd_addr != 12'hE3C
                                    |=> rd_data == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  a_bus_term: assert property (clk_en && ch1_ev.ack_valid && ch1_ev.ack_bus_err
                               |=> ch1_cmd.terminate && !ch1_cmd.retry_again)
    else $error("bus error did not terminate the operation");
  a_retry_reply: assert property (clk_en && ch1_ev.ack_valid && ch1_ev.ack_retry && !ch1_ev.ack_bus_err
                                  |=> ch1_cmd.retry_again != ch1_cmd.terminate)
    else $error("retry acknowledge got no single reply");
  a_cmd_idle: assert property (clk_en && !ch2_ev.ack_valid |=> ch2_cmd == 2'h0)
    else $error("command issued without an acknowledge");
endmodule
bind dma_status_top dma_status_props u_dma_status_props (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
  .ch1_ev(ch1_ev), .ch2_ev(ch2_ev), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
  .rd_valid(rd_valid), .ch1_done_irq_src(ch1_done_irq_src), .ch2_done_irq_src(ch2_done_irq_src),
  .ch1_cmd(ch1_cmd), .ch2_cmd(ch2_cmd));

/* dma_status_top_tb_top.sv */
// self-checking bench for the two-channel status block
// assumes the design package is compiled first; the bench drives all ports
`timescale 1ns/1ps
module dma_status_top_tb_top;
  logic                        mclk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        clk_en = 1'b1;
  logic                        rd_en = 1'b0;
  logic [11:0]                 rd_addr = 12'h000;
  dma_status_pkg::chan_event_t ev1 = '0;
  dma_status_pkg::chan_event_t ev2 = '0;
  logic [31:0]                 rd_data;
  logic                        rd_valid;
  logic                        d1;
  logic                        d2;
  dma_status_pkg::chan_cmd_t   cmd1;
  dma_status_pkg::chan_cmd_t   cmd2;
  dma_status_pkg::chan_cmd_t   cmd_seen;
  int                          mismatches = 0;
  int                          n_checks = 0;
  always #10 mclk = ~mclk;
  dma_status_top u_dma_status_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ch1_ev(ev1), .ch2_ev(ev2),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .ch1_done_irq_src(d1),
    .ch2_done_irq_src(d2), .ch1_cmd(cmd1), .ch2_cmd(cmd2));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  // event codes: 400 start, 200 end, 100 abort, 080 stop, 040 xfer done,
  // 020 ack, 010 dest side, 008 bus error, 004 retry, 002 parity, 001 irq
  // extra cycle after each pulse keeps a driver from writing twice in one step
  task automatic pulse(input logic ch, input logic [10:0] e);
    if (ch) ev2 = e;
    else ev1 = e;
    step;
    ev1 = '0;
    ev2 = '0;
    cmd_seen = ch ? cmd2 : cmd1;
    step;
  endtask
  // reserved bits masked: their value carries no meaning
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_en = 1'b1;
    rd_addr = a;
    step;
    rd_en = 1'b0;
    chk({rd_valid, rd_data & 32'h8200_D20F}, {1'b1, e});
    step;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_irq;
    rd(12'hD40, 32'h0000_0000);
    ev1 = 11'h001;
    step;
    rd(12'hD3C, 32'h8000_0000);
    rd(12'hE3C, 32'h0000_0000);
    ev1 = '0;
    step;
    rd(12'hD3C, 32'h0000_0000);
  endtask
  task automatic t_done;
    pulse(1'b0, 11'h400);
    chk({32'h0, d1}, 33'h0);
    pulse(1'b0, 11'h200);
    rd(12'hD3C, 32'h0200_0000);
    chk({32'h0, d1}, 33'h1);
    pulse(1'b0, 11'h400);
    rd(12'hD3C, 32'h0000_0000);
  endtask
  task automatic t_faults;
    logic [10:0] ev [3] = '{11'h028, 11'h022, 11'h038};
    logic [31:0] ex [3] = '{32'h0200_8204, 32'h0200_820C, 32'h0200_8201};
    for (int i = 0; i < 3; i++) begin
      pulse(i == 2, 11'h400);
      pulse(i == 2, ev[i]);
      chk({31'h0, cmd_seen}, 33'h1);
      pulse(i == 2, 11'h200);
      rd(i == 2 ? 12'hE3C : 12'hD3C, ex[i]);
    end
  endtask
  task automatic t_retry;
    pulse(1'b0, 11'h400);
    for (int i = 0; i < 40; i++) pulse(1'b0, 11'h034);
    pulse(1'b0, 11'h040);
    for (int i = 0; i < 64; i++) begin
      pulse(1'b0, 11'h034);
      chk({31'h0, cmd_seen}, 33'h2);
    end
    pulse(1'b0, 11'h034);
    chk({31'h0, cmd_seen}, 33'h1);
    pulse(1'b0, 11'h200);
    rd(12'hD3C, 32'h0200_8202);
    pulse(1'b0, 11'h400);
    rd(12'hD3C, 32'h0000_0000);
  endtask
  task automatic t_cancel;
    pulse(1'b1, 11'h400);
    pulse(1'b1, 11'h080);
    rd(12'hE3C, 32'h0000_1000);
    pulse(1'b1, 11'h100);
    pulse(1'b1, 11'h200);
    rd(12'hE3C, 32'h0200_5000);
    chk({32'h0, d2}, 33'h1);
    pulse(1'b1, 11'h400);
    rd(12'hE3C, 32'h0000_0000);
  endtask
  // frozen clock enable drops events; then a reset in mid-run clears state
  task automatic t_freeze;
    clk_en = 1'b0;
    pulse(1'b0, 11'h228);
    chk({31'h0, cmd_seen}, 33'h0);
    clk_en = 1'b1;
    rd(12'hD3C, 32'h0000_0000);
    pulse(1'b1, 11'h200);
    chk({32'h0, d2}, 33'h1);
    rst_n = 1'b0;
    step;
    chk({32'h0, d2}, 33'h0);
    rst_n = 1'b1;
    rd(12'hE3C, 32'h0000_0000);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    t_irq;
    t_done;
    t_faults;
    t_retry;
    t_cancel;
    t_freeze;
    report_and_stop;
  end
  // whole run is well under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
endmodule
